/* File: rtl/vcrp_pkg.sv */
/*
  Constants, types and helper functions of the crypto request parser.
  Assumes a single 100 MHz clock domain; requests arrive as 32-bit
  little-endian words, first word first.
*/
package vcrp_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  // ==========================================================
  localparam logic [7:0]  REG_CTRL      = 8'h00;  // Feature bits
  localparam logic [7:0]  REG_MASK_BASE = 8'h04;  // Four algo masks, one per service
  localparam logic [7:0]  REG_MASK_LAST = 8'h10;
  localparam logic [7:0]  REG_STAT      = 8'h14;  // Last status, live sessions, busy
  localparam logic [7:0]  REG_SID_LO    = 8'h18;  // Last session id handed out
  localparam logic [7:0]  REG_SID_HI    = 8'h1C;
  localparam logic [7:0]  REG_DONE_CNT  = 8'h20;  // Completed requests
  localparam int          CTRL_REV1_BIT = 0;      // Revision-1 negotiated
  localparam int          CTRL_SL_BIT0  = 1;      // Stateless bits 1..4, by service code
  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  localparam logic [31:0] MASK_RESET    = 32'hFFFF_FFFF;
  localparam int          STAT_LIVE_LSB = 8;
  localparam int          STAT_BUSY_BIT = 16;

  // ==========================================================
  // Opcode, flag and status encodings
  // ==========================================================
  localparam logic [7:0]  SVC_CIPHER   = 8'h00;
  localparam logic [7:0]  SVC_HASH     = 8'h01;
  localparam logic [7:0]  SVC_MAC      = 8'h02;
  localparam logic [7:0]  SVC_AEAD     = 8'h03;
  localparam logic [7:0]  SUB_ENC      = 8'h00;  // Also hash and MAC
  localparam logic [7:0]  SUB_DEC      = 8'h01;
  localparam logic [7:0]  SUB_CREATE   = 8'h02;
  localparam logic [7:0]  SUB_DESTROY  = 8'h03;
  localparam logic [31:0] DIR_ENCRYPT  = 32'h0000_0001;
  localparam logic [31:0] DIR_DECRYPT  = 32'h0000_0002;
  localparam logic [31:0] FLAG_SESSION = 32'h0000_0001;
  localparam logic [7:0]  ST_OK        = 8'h00;
  localparam logic [7:0]  ST_ERR       = 8'h01;
  localparam logic [7:0]  ST_NOTSUPP   = 8'h03;
  localparam logic [7:0]  ST_INVSESS   = 8'h04;
  localparam logic [7:0]  ST_NOSPC     = 8'h05;

  // ==========================================================
  // Layout sizes in 32-bit words
  // ==========================================================
  localparam logic [15:0] CTRL_HDR_W    = 16'd4;
  localparam logic [15:0] DATA_HDR_W    = 16'd6;
  localparam logic [15:0] CTRL_LEGACY_W = 16'(56 / 4);
  localparam logic [15:0] DATA_LEGACY_W = 16'(48 / 4);
  localparam logic [15:0] AEAD_CS_W     = 16'd6;
  localparam logic [15:0] HASH_CS_W     = 16'd2;
  localparam logic [15:0] MAC_CS_W      = 16'd4;
  localparam logic [15:0] CIPHER_CS_W   = 16'd12;
  localparam logic [15:0] DESTROY_W     = 16'd2;
  localparam logic [15:0] SESS_D_W      = 16'd2;
  localparam logic [15:0] STATELESS_D_W = 16'd4;
  localparam int          CAP_FLF       = 6;      // Fixed-part words kept
  localparam int          NSESS         = 8;      // Session slots
  localparam logic [63:0] SID_FIRST     = 64'h0000_0000_0000_0001;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_RECV   = 7'b0000010,
    ST_DECIDE = 7'b0000100,
    ST_SID_LO = 7'b0001000,
    ST_SID_HI = 7'b0010000,
    ST_ENGINE = 7'b0100000,
    ST_STATUS = 7'b1000000
  } vcrp_state_type;

  // Byte count rounded up to whole words
  function automatic logic [31:0] words_of(input logic [31:0] len);
    logic [32:0] s;
    s = {1'b0, len} + 33'h0_0000_0003;
    return {1'b0, s[32:2]};
  endfunction

  // Fixed part of a control request, zero for unknown opcodes
  function automatic logic [15:0] ctrl_flf_w(input logic [7:0] svc, input logic destroy,
                                             input logic rev1, input logic known);
    logic [15:0] n;
    n = 16'h0;
    if (!known) begin
      n = 16'h0;
    end else if (!rev1) begin
      n = CTRL_LEGACY_W;
    end else if (destroy) begin
      n = DESTROY_W;
    end else begin
      unique case (svc)
        SVC_HASH: n = HASH_CS_W;
        SVC_MAC:  n = MAC_CS_W;
        SVC_AEAD: n = AEAD_CS_W;
        default:  n = CIPHER_CS_W;
      endcase
    end
    return n;
  endfunction

  // Fixed part of a data request (hash and MAC layouts)
  function automatic logic [15:0] data_flf_w(input logic known, input logic rev1,
                                             input logic stateless);
    logic [15:0] n;
    n = 16'h0;
    if (!known) begin
      n = 16'h0;
    end else if (stateless) begin
      n = STATELESS_D_W;
    end else if (rev1) begin
      n = SESS_D_W;
    end else begin
      n = DATA_LEGACY_W;
    end
    return n;
  endfunction

endpackage

/* File: rtl/vcrp_sess_table.sv */
/*
  Session table: allocates unique 64-bit session ids, looks them up
  and frees them. Lookup results are combinational from the id input.
  Assumes alloc and free are never requested in the same cycle.
*/
`timescale 1ns/1ps
module vcrp_sess_table (
  input  wire logic        clk_sys_i,   // System clock
  input  wire logic        rst_n_i,     // Async reset, active low
  input  wire logic        alloc_i,     // Take a free slot
  input  wire logic [7:0]  alloc_svc_i, // Service of new session
  input  wire logic        free_i,      // Release the hit slot
  input  wire logic [63:0] look_id_i,   // Id to look up
  output logic             hit_o,       // Id is live
  output logic [7:0]       hit_svc_o,   // Service of the hit
  output logic             full_o,      // No free slot
  output logic [63:0]      new_id_o,    // Id that alloc will hand out
  output logic [3:0]       live_o       // Live session count
);
  import vcrp_pkg::*;

  // ==========================================================
  // Slot storage
  // ==========================================================
  logic [NSESS-1:0] valid_r;            // Slot in use
  logic [63:0]      id_r [NSESS];       // Id per slot
  logic [7:0]       svc_r [NSESS];      // Service per slot
  logic [63:0]      serial_r;           // Never reused, so ids stay unique
  logic [2:0]       hit_idx;
  logic [2:0]       free_idx;

  // Search for a matching slot and the lowest free one
  always_comb begin
    hit_o     = 1'b0;
    hit_idx   = 3'h0;
    full_o    = 1'b1;
    free_idx  = 3'h0;
    live_o    = 4'h0;
    for (int i = NSESS - 1; i >= 0; i--) begin
      if (valid_r[i] && id_r[i] == look_id_i) begin
        hit_o   = 1'b1;
        hit_idx = 3'(i);
      end
      if (!valid_r[i]) begin
        full_o   = 1'b0;
        free_idx = 3'(i);
      end
      live_o = live_o + {3'h0, valid_r[i]};
    end
  end

  assign hit_svc_o = svc_r[hit_idx];
  assign new_id_o  = serial_r;

  // Slot update; ids only come from the serial counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_r  <= '0;
      serial_r <= SID_FIRST;
      for (int i = 0; i < NSESS; i++) begin
        id_r[i]  <= 64'h0;
        svc_r[i] <= 8'h00;
      end
    end else if (alloc_i && !full_o) begin
      valid_r[free_idx] <= 1'b1;
      id_r[free_idx]    <= serial_r;
      svc_r[free_idx]   <= alloc_svc_i;
      serial_r          <= serial_r + 64'h1;
    end else if (free_i && hit_o) begin
      valid_r[hit_idx] <= 1'b0;
    end
  end

endmodule

/* File: rtl/vcrp_parser.sv */
/*
  Crypto request parser: takes control-queue and data-queue requests
  word by word, picks the layout from the opcode, answers sessions
  itself and hands hash and MAC jobs to an external engine.
  Assumes the engine writes its result data before raising done.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module vcrp_parser (
  input  wire logic        clk_sys_i,      // System clock
  input  wire logic        rst_n_i,        // Async reset, active low
  input  wire logic [7:0]  reg_addr_i,     // Register byte address
  input  wire logic [31:0] reg_wdata_i,    // Register write data
  input  wire logic        reg_wr_i,       // Write strobe
  input  wire logic        reg_rd_i,       // Read strobe
  output logic [31:0]      reg_rdata_o,    // Read data, one cycle later
  input  wire logic        req_valid_i,    // Request word valid
  input  wire logic        req_ctrl_i,     // Control queue, with first word
  input  wire logic [31:0] req_data_i,     // Request word, little endian
  input  wire logic        req_last_i,     // Last word of request
  output logic             req_ready_o,    // Word taken when valid too
  output logic             res_valid_o,    // Outcome word valid
  output logic [1:0]       res_word_o,     // Outcome word index
  output logic [31:0]      res_data_o,     // Outcome word
  output logic             stat_valid_o,   // Status byte valid
  output logic [7:0]       stat_o,         // Status byte
  output logic             job_valid_o,    // Job dispatch pulse
  output logic [7:0]       job_svc_o,      // Hash or MAC
  output logic             job_stateless_o,
  output logic [31:0]      job_algo_o,
  output logic [63:0]      job_sid_o,
  output logic [31:0]      job_src_len_o,
  output logic [31:0]      job_res_len_o,
  output logic [31:0]      job_key_len_o,
  input  wire logic        eng_done_i,     // Engine finished, results written
  input  wire logic [7:0]  eng_status_i    // Engine status
);
  import vcrp_pkg::*;

  // ==========================================================
  // Registers
  // ==========================================================
  vcrp_state_type state_r, state_nxt;    // Request sequencer
  logic [4:0]   ctrl_r;                  // Rev1 and stateless features
  logic [31:0]  mask_r [4];              // Supported algorithms per service
  logic [31:0]  w_r [12];                // Header words 0..5, fixed words 6..11
  logic [15:0]  widx_r;                  // Words taken in this request
  logic         is_ctrl_r;               // Control queue request
  logic [7:0]   code_r;                  // Status to report
  logic [63:0]  sid_r;                   // Last session id handed out
  logic [31:0]  done_cnt_r;              // Completed requests
  logic [31:0]  rdata_r;

  // ==========================================================
  // Request word capture
  // ==========================================================
  wire        acc        = req_valid_i && req_ready_o;
  wire        ctrl_now   = (state_r == ST_IDLE) ? req_ctrl_i : is_ctrl_r;
  wire        rev1       = ctrl_r[CTRL_REV1_BIT];
  wire [7:0]  svc        = w_r[0][15:8];
  wire [7:0]  sub        = w_r[0][7:0];
  wire        hi_zero    = (w_r[0][31:16] == 16'h0);
  wire        c_create   = (sub == SUB_CREATE);
  wire        c_destroy  = (sub == SUB_DESTROY);
  wire        c_known    = hi_zero && (svc <= SVC_AEAD) && (c_create || c_destroy);
  wire        d_hm       = (svc == SVC_HASH || svc == SVC_MAC) && (sub == SUB_ENC);
  wire        d_ca       = (svc == SVC_CIPHER || svc == SVC_AEAD) && (sub <= SUB_DEC);
  wire        d_known    = hi_zero && (d_hm || d_ca);
  wire        sl_feat    = ctrl_r[CTRL_SL_BIT0 + 32'(svc[1:0])];
  wire        flag_sess  = (w_r[4] == FLAG_SESSION);
  wire        sess_mode  = !rev1 || flag_sess;
  wire        stateless  = rev1 && sl_feat && !flag_sess;
  wire        reject     = rev1 && !sl_feat && !flag_sess;
  wire [15:0] hdr_n      = ctrl_now ? CTRL_HDR_W : DATA_HDR_W;
  // Layout chosen from the opcode; cipher/AEAD data layouts are not parsed
  wire [15:0] flf_n      = is_ctrl_r ? ctrl_flf_w(svc, c_destroy, rev1, c_known)
                                     : data_flf_w(d_known && d_hm, rev1, stateless);
  wire [15:0] rel        = widx_r - hdr_n;
  wire        cap_hdr    = (widx_r < hdr_n);
  wire        cap_flf    = !cap_hdr && (rel < flf_n) && (rel < 16'(CAP_FLF));
  wire [3:0]  cap_idx    = cap_hdr ? widx_r[3:0] : 4'(rel + 16'(CAP_FLF));

  // ==========================================================
  // Decision from the captured request
  // ==========================================================
  wire        short_req  = (widx_r < hdr_n + flf_n);
  wire [15:0] vlf_n      = widx_r - hdr_n - flf_n;
  wire [31:0] key_len    = (svc == SVC_MAC) ? w_r[8] : ((svc == SVC_HASH) ? 32'h0 : w_r[7]);
  wire        key_ok     = ({16'h0, vlf_n} == words_of(key_len));
  wire [1:0]  msel       = svc[1:0];
  wire        algo_ok    = (w_r[6][31:5] == 27'h0) && mask_r[msel][w_r[6][4:0]];
  wire [31:0] dir_w      = (svc == SVC_AEAD) ? w_r[10] : w_r[8];
  wire        dir_ok     = (svc == SVC_HASH || svc == SVC_MAC) || dir_w == DIR_ENCRYPT
                           || dir_w == DIR_DECRYPT;
  wire [63:0] look_id    = is_ctrl_r ? {w_r[7], w_r[6]} : {w_r[3], w_r[2]};
  logic        tab_hit, tab_full;
  logic [7:0]  tab_svc;
  logic [63:0] tab_new_id;
  logic [3:0]  tab_live;
  wire        sess_ok    = tab_hit && (tab_svc == svc);
  wire        decide     = (state_r == ST_DECIDE);
  logic [7:0] dec_code;                  // Status decided now
  logic       dec_alloc;                 // Create succeeds
  logic       dec_free;                  // Destroy succeeds
  logic       dec_job;                   // Hand to engine

  // Status priority per request kind
  always_comb begin
    dec_code  = ST_OK;
    dec_alloc = 1'b0;
    dec_free  = 1'b0;
    dec_job   = 1'b0;
    if (is_ctrl_r) begin
      if (!c_known) begin
        dec_code = ST_NOTSUPP;
      end else if (short_req) begin
        dec_code = ST_ERR;
      end else if (c_destroy) begin
        dec_code = sess_ok ? ST_OK : ST_ERR;
        dec_free = sess_ok;
      end else if (!algo_ok || !dir_ok) begin
        dec_code = ST_NOTSUPP;
      end else if (!key_ok) begin
        dec_code = ST_ERR;
      end else if (tab_full) begin
        dec_code = rev1 ? ST_NOSPC : ST_ERR;
      end else begin
        dec_alloc = 1'b1;
      end
    end else begin
      if (!d_known || d_ca) begin
        dec_code = ST_NOTSUPP;
      end else if (short_req || reject) begin
        dec_code = ST_ERR;
      end else if (sess_mode && !sess_ok) begin
        dec_code = ST_INVSESS;
      end else if (stateless && !algo_ok) begin
        dec_code = ST_NOTSUPP;
      end else begin
        dec_job = 1'b1;
      end
    end
  end

  // Session ids live in a small table; a destroyed id never returns
  vcrp_sess_table u_table (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .alloc_i     (decide && dec_alloc),
    .alloc_svc_i (svc),
    .free_i      (decide && dec_free),
    .look_id_i   (look_id),
    .hit_o       (tab_hit),
    .hit_svc_o   (tab_svc),
    .full_o      (tab_full),
    .new_id_o    (tab_new_id),
    .live_o      (tab_live)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   if (acc) state_nxt = req_last_i ? ST_DECIDE : ST_RECV;
      ST_RECV:   if (acc && req_last_i) state_nxt = ST_DECIDE;
      ST_DECIDE: begin
        if (dec_alloc) begin
          state_nxt = ST_SID_LO;
        end else if (dec_job) begin
          state_nxt = ST_ENGINE;
        end else begin
          state_nxt = ST_STATUS;
        end
      end
      ST_SID_LO: state_nxt = ST_SID_HI;
      ST_SID_HI: state_nxt = ST_STATUS;
      ST_ENGINE: if (eng_done_i) state_nxt = ST_STATUS;
      ST_STATUS: state_nxt = ST_IDLE;
    endcase
  end

  // State, word index and capture
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= ST_IDLE;
      widx_r    <= 16'h0;
      is_ctrl_r <= 1'b0;
      for (int i = 0; i < 12; i++) begin
        w_r[i] <= 32'h0;
      end
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        is_ctrl_r <= req_ctrl_i;
        widx_r    <= 16'h0;
        for (int i = 0; i < 12; i++) begin
          w_r[i] <= 32'h0;     // Absent words read as zero
        end
      end
      if (acc) begin
        widx_r <= (state_r == ST_IDLE) ? 16'h1 : widx_r + 16'h1;
        if (cap_hdr || cap_flf) begin
          w_r[cap_idx] <= req_data_i;
        end
      end
    end
  end

  // Status code and session id latch
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_r <= ST_OK;
      sid_r  <= 64'h0;
    end else if (decide) begin
      code_r <= dec_code;
      if (dec_alloc) begin
        sid_r <= tab_new_id;
      end
    end else if (state_r == ST_ENGINE && eng_done_i) begin
      code_r <= eng_status_i;
    end
  end

  // ==========================================================
  // Outputs, all registered
  // ==========================================================
  wire        go_job   = decide && dec_job;
  wire [31:0] j_src    = !stateless ? w_r[6] : ((svc == SVC_MAC) ? w_r[8] : w_r[7]);
  wire [31:0] j_res    = !stateless ? w_r[7] : ((svc == SVC_MAC) ? w_r[9] : w_r[8]);
  wire [31:0] j_key    = (stateless && svc == SVC_MAC) ? w_r[7] : 32'h0;
  wire [31:0] j_algo   = stateless ? w_r[6] : w_r[1];

  // Outcome words, status byte and job pulse
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ready_o     <= 1'b0;
      res_valid_o     <= 1'b0;
      res_word_o      <= 2'h0;
      res_data_o      <= 32'h0;
      stat_valid_o    <= 1'b0;
      stat_o          <= ST_OK;
      job_valid_o     <= 1'b0;
      job_svc_o       <= 8'h00;
      job_stateless_o <= 1'b0;
      job_algo_o      <= 32'h0;
      job_sid_o       <= 64'h0;
      job_src_len_o   <= 32'h0;
      job_res_len_o   <= 32'h0;
      job_key_len_o   <= 32'h0;
    end else begin
      req_ready_o  <= (state_nxt == ST_IDLE) || (state_nxt == ST_RECV);
      res_valid_o  <= (state_r == ST_SID_LO) || (state_r == ST_SID_HI);
      res_word_o   <= (state_r == ST_SID_HI) ? 2'h1 : 2'h0;
      res_data_o   <= (state_r == ST_SID_HI) ? sid_r[63:32] : sid_r[31:0];
      stat_valid_o <= (state_r == ST_STATUS);
      stat_o       <= code_r;
      job_valid_o  <= go_job;
      if (go_job) begin
        job_svc_o       <= svc;
        job_stateless_o <= stateless;
        job_algo_o      <= j_algo;
        job_sid_o       <= {w_r[3], w_r[2]};
        job_src_len_o   <= j_src;
        job_res_len_o   <= j_res;
        job_key_len_o   <= j_key;
      end
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  wire        sel_mask = (reg_addr_i >= REG_MASK_BASE) && (reg_addr_i <= REG_MASK_LAST)
                         && (reg_addr_i[1:0] == 2'h0);
  wire [7:0]  mofs     = reg_addr_i - REG_MASK_BASE;
  wire [1:0]  midx     = mofs[3:2];
  wire        busy     = (state_r != ST_IDLE);
  wire [31:0] stat_w   = {15'h0, busy, 4'h0, tab_live, code_r};
  logic [31:0] rd_mux;

  // Read select; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    if (sel_mask) begin
      rd_mux = mask_r[midx];
    end else begin
      case (reg_addr_i)
        REG_CTRL:     rd_mux = {27'h0, ctrl_r};
        REG_STAT:     rd_mux = stat_w;
        REG_SID_LO:   rd_mux = sid_r[31:0];
        REG_SID_HI:   rd_mux = sid_r[63:32];
        REG_DONE_CNT: rd_mux = done_cnt_r;
        default:      rd_mux = 32'h0;
      endcase
    end
  end

  // Writes, read data and completion count
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r     <= CTRL_RESET;
      done_cnt_r <= 32'h0;
      rdata_r    <= 32'h0;
      for (int i = 0; i < 4; i++) begin
        mask_r[i] <= MASK_RESET;
      end
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : 32'h0;
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        ctrl_r <= reg_wdata_i[4:0];
      end
      if (reg_wr_i && sel_mask) begin
        mask_r[midx] <= reg_wdata_i;
      end
      if (state_r == ST_STATUS) begin
        done_cnt_r <= done_cnt_r + 32'h1;
      end
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

/* File: dv/vcrp_sva.sv */
/* Port checker for the request parser.
   Assumes one clock domain; bound from the bench top file. */
`timescale 1ns/1ps
module vcrp_sva (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        req_valid_i,
  input wire logic        req_last_i,
  input wire logic        req_ready_o,
  input wire logic        res_valid_o,
  input wire logic [1:0]  res_word_o,
  input wire logic        stat_valid_o,
  input wire logic [7:0]  stat_o,
  input wire logic        job_valid_o,
  input wire logic        eng_done_i,
  input wire logic [7:0]  eng_status_i
);
  // ==========================================
  // Port timing
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire tk = req_valid_i && req_ready_o && req_last_i; // Last word taken
  property p_ans;
    tk |-> ##1 !(res_valid_o || stat_valid_o || job_valid_o) ##1 !(res_valid_o || stat_valid_o)
       ##1 (res_valid_o || stat_valid_o || $past(job_valid_o));
  endproperty
  a_ans: assert property (p_ans) else $error("answer late or early");
  property p_busy; tk |=> !req_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready after last word");
  property p_rdy; stat_valid_o |-> req_ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("not ready at status");
  property p_sid;
    res_valid_o && res_word_o == 2'h0 |=> res_valid_o && res_word_o == 2'h1 ##1 stat_valid_o && stat_o == 8'h00;
  endproperty
  a_sid: assert property (p_sid) else $error("id words not followed by OK");
  property p_nsid; stat_valid_o && stat_o != 8'h00 |-> !$past(res_valid_o); endproperty
  a_nsid: assert property (p_nsid) else $error("id written on failure");
  property p_eng; eng_done_i && !req_ready_o |-> ##2 stat_valid_o && stat_o == $past(eng_status_i, 2); endproperty
  a_eng: assert property (p_eng) else $error("engine status not passed");
  property p_job; job_valid_o |-> !req_ready_o [*3]; endproperty
  a_job: assert property (p_job) else $error("ready while job runs");
  property p_rd; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data not idle zero");
endmodule

/* File: dv/vcrp_eng_model.sv */
/* Engine stand-in: answers each job some cycles later.
   Assumes one job at a time; the bench picks the status. */
`timescale 1ns/1ps
module vcrp_eng_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       job_i,
  input  wire logic [7:0] sts_i,
  output logic            done_o,
  output logic [7:0]      status_o
);
  // ==========================================
  // Delay counter
  logic [3:0] cnt_r; // Cycles left
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_r <= 4'h0;
    else if (job_i) cnt_r <= 4'h5;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  // Done for one cycle, five cycles after the job; until then the status shows the inverse of the bench's pick
  assign done_o = cnt_r == 4'h1;
  assign status_o = done_o ? sts_i : ~sts_i;
endmodule

/* File: dv/vcrp_parser_test.sv */
/* Bench for the request parser: registers, sessions, hash jobs.
   Assumes the encodings of vcrp_pkg. */
`timescale 1ns/1ps
module vcrp_parser_test;
  import vcrp_pkg::*;
  // ==========================================
  // Signals
  logic clk_sys_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, req_valid_i = 0, req_ctrl_i = 0, req_last_i = 0;
  logic [7:0] reg_addr_i = 8'h0, sts = 8'h0, stat_o, eng_status_i;
  logic [31:0] reg_wdata_i = 32'h0, req_data_i = 32'h0, reg_rdata_o, res_data_o, job_algo_o;
  logic [63:0] sid = 64'h0;
  logic [1:0] res_word_o;
  logic [7:0] job_svc_o;
  logic [31:0] job_src_len_o, job_res_len_o, job_key_len_o;
  logic [63:0] job_sid_o;
  logic req_ready_o, res_valid_o, stat_valid_o, job_valid_o, job_stateless_o, eng_done_i;
  int err_total = 0, checked = 0, cyc = 0;
  vcrp_parser i_vcrp_parser (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .req_valid_i, .req_ctrl_i, .req_data_i, .req_last_i, .req_ready_o, .res_valid_o,
    .res_word_o, .res_data_o, .stat_valid_o, .stat_o, .job_valid_o, .job_svc_o, .job_stateless_o,
    .job_algo_o, .job_sid_o, .job_src_len_o, .job_res_len_o, .job_key_len_o, .eng_done_i, .eng_status_i);
  vcrp_eng_model i_vcrp_eng_model (.clk_sys_i, .rst_n_i, .job_i(job_valid_o), .sts_i(sts),
    .done_o(eng_done_i), .status_o(eng_status_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // Session id words as handed out
  always @(posedge clk_sys_i) if (res_valid_o) sid[res_word_o[0]*32 +: 32] <= res_data_o;
  // Hang guard
  always @(posedge clk_sys_i) if (++cyc > 3000) begin
    err_total++;
    wrap_up();
  end
  task chk(input logic [63:0] g, e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i) reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i) reg_rd_i <= 1'b0;
    @(negedge clk_sys_i) chk(reg_rdata_o, e);
    @(posedge clk_sys_i);
  endtask
  // One request, words held until taken, then its status
  task send(input logic c, input logic [31:0] w[$], input logic [7:0] e);
    int n;
    foreach (w[i]) begin
      req_valid_i <= 1'b1;
      req_ctrl_i <= c;
      req_data_i <= w[i];
      req_last_i <= i == w.size() - 1;
      do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
    end
    req_valid_i <= 1'b0;
    for (n = 0; n < 99 && stat_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk({stat_valid_o, stat_o}, {1'b1, e});
    @(posedge clk_sys_i);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rd(REG_CTRL, 32'h0);
    rd(REG_MASK_BASE, MASK_RESET);
    rd(8'h40, 32'h0);
    wr(REG_CTRL, 32'h1);
    send(1, '{32'h302, 0, 0, 0, 0, 8, 16, 0, 1, 0, 32'h11, 32'h22}, ST_OK);
    chk(sid, 64'h1);
    send(1, '{32'h302, 0, 0, 0, 0, 8, 16, 0, 1, 0, 32'h11, 32'h22, 3}, ST_ERR);
    send(1, '{32'h103, 0, 0, 0, 1, 0}, ST_ERR);
    send(1, '{32'h303, 0, 0, 0, 1, 0}, ST_OK);
    send(1, '{32'h702, 0, 0, 0}, ST_NOTSUPP);
    send(0, '{32'h100, 0, 5, 0, 1, 0, 4, 4, 32'hAB}, ST_INVSESS);
    send(0, '{32'h100, 0, 5, 0, 0, 0, 4, 4, 32'hAB}, ST_ERR);
    wr(REG_CTRL, 32'h0);
    send(0, '{32'h100, 0, 5, 0, 0, 0, 4, 4, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}, ST_INVSESS);
    wr(REG_CTRL, 32'h5);
    send(1, '{32'h102, 0, 0, 0, 0, 4}, ST_OK);
    send(0, '{32'h100, 0, 2, 0, 1, 0, 4, 8, 32'hAB}, ST_OK);
    chk(job_stateless_o, 1'b0);
    chk(job_sid_o, 64'h2);
    chk({job_src_len_o, job_res_len_o}, {32'h4, 32'h8});
    sts <= ST_ERR;
    send(0, '{32'h100, 2, 0, 0, 0, 0, 2, 6, 8, 0, 32'hAB}, ST_ERR);
    chk({job_stateless_o, job_algo_o}, 33'h1_0000_0002);
    chk({job_src_len_o, job_res_len_o}, {32'h6, 32'h8});
    chk({job_svc_o, job_key_len_o}, {SVC_HASH, 32'h0});
    rd(REG_SID_LO, 32'h2);
    send(1, '{32'h202, 0, 0, 0, 0, 8, 4, 0, 32'h11}, ST_OK);
    chk(sid, 64'h3);
    send(0, '{32'h200, 0, 3, 0, 1, 0, 32'hA, 32'hC, 32'hAB, 32'hCD}, ST_ERR);
    chk({job_svc_o, job_sid_o[31:0]}, {SVC_MAC, 32'h3});
    chk({job_src_len_o, job_res_len_o}, {32'hA, 32'hC});
    wrap_up();
  end
endmodule
bind vcrp_parser vcrp_sva i_vcrp_sva (.*);
